// ==== logic/qdcrb_pkg.sv ====
// Package: register offsets, field positions, reset values and timing for the control register bank
package qdcrb_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [15:0] OFF_FAST_CLEAR_WINDOW   = 16'h102e;
	localparam logic [15:0] OFF_MODE_SET            = 16'h1032;
	localparam logic [15:0] OFF_MODE_CLEAR          = 16'h1034;
	localparam logic [15:0] OFF_TEST_WRITE_ADDRESS  = 16'h1036;
	localparam logic [15:0] OFF_TEST_WORD_UPPER     = 16'h1038;
	localparam logic [15:0] OFF_TEST_WORD_LOWER     = 16'h103a;
	localparam logic [15:0] OFF_CRATE_NUMBER        = 16'h103c;
	localparam logic [15:0] OFF_TEST_EVENT_FIFO     = 16'h103e;
	localparam logic [15:0] OFF_EVENT_COUNTER_CLEAR = 16'h1040;
	localparam logic [15:0] OFF_PEDESTAL_CURRENT    = 16'h1060;
	// ==========================================================
	// Mode register field positions
	localparam int MB_MEMORY_TEST         = 0;
	localparam int MB_CONVERTER_HALT      = 1;
	localparam int MB_DATA_WIPE           = 2;
	localparam int MB_OVERFLOW_CHECK_DIS  = 3;
	localparam int MB_THRESHOLD_CHECK_DIS = 4;
	localparam int MB_ACQUISITION_TEST    = 6;
	localparam int MB_SLIDING_SCALE_EN    = 7;
	localparam int MB_THRESHOLD_RES       = 8;
	localparam int MB_AUTO_ADVANCE        = 11;
	localparam int MB_KEEP_EMPTY          = 12;
	localparam int MB_SLIDE_SUB_DIS       = 13;
	localparam int MB_COUNT_EVERY_TRIGGER = 14;
	// Writable mode positions; all others are reserved and kept
	localparam logic [15:0] MODE_WRITABLE = 16'h79df;
	// ==========================================================
	// Reset values
	localparam logic [15:0] MODE_RESET     = 16'h4880;
	localparam logic [9:0]  FCW_RESET      = 10'h000;
	localparam logic [7:0]  PEDESTAL_RESET = 8'hb4;
	localparam logic [7:0]  CRATE_RESET    = 8'h00;
	// ==========================================================
	// Field widths and limits
	localparam int          FCW_BITS      = 10;
	localparam logic [9:0]  FCW_MAX       = 10'h3f0;
	localparam int          TEST_WORD_BITS = 13;
	localparam int          EVCNT_BITS    = 24;
	// ==========================================================
	// Fast clear window timing: base in ns, tick rate 32 MHz, system clock 125 MHz
	localparam int FC_BASE_NS       = 7000;
	localparam int SYS_CLK_MHZ      = 125;
	localparam int FC_TICK_MHZ      = 32;
	localparam int FC_BASE_CYCLES   = (FC_BASE_NS * SYS_CLK_MHZ + 999) / 1000;
endpackage

// ==== logic/qdcrb_control_register_bank.sv ====
// Control and configuration register bank of the charge converter module
// Notes on behaviour
// R1 - Fast clear window holds 10-bit N; width is N/32 us plus 7 us; N at most 3f0.
// R2 - Mode-set write sets each bit written one; others keep; read returns mode.
// R3 - Mode-clear write clears each bit written one; others keep.
// R4 - Mode bit 0 selects memory test, host writes buffer directly.
// R5 - Converter-halt bit set keeps converter offline, no conversions.
// R6 - Data-wipe bit set produces data reset of data, pointers, counter, integrators.
// R7 - Overflow check disable zero stores only non-overflow samples; one stores all.
// R8 - Threshold check disable zero stores only samples above threshold.
// R9 - Acquisition test bit takes stored data from internal test event FIFO.
// R10 - Sliding scale disabled drives DAC with constant; test bit disables subtraction only.
// R11 - Threshold resolution picks threshold times 16 or times 2 for suppression.
// R12 - Auto advance moves read pointer; else only next-event or next-word strobes.
// R13 - Keep-empty bit writes header and trailer for events with no accepted channels.
// R14 - Count-every-trigger zero counts accepted triggers only; one counts all.
// R15 - Low test half write transfers full 32-bit test word to test write address.
// R16 - Host writes test mode, address, high half, then low half.
// R17 - Host keeps test read address different from test write address.
// R18 - Host loads crate number; device inserts it into produced data words.
// R19 - Test event writes push 16-bit words of value and overflow into 32-word FIFO.
// R20 - Host writes exactly 32 test words in readout order.
// R21 - Any write to event counter clear strobe clears the event counter.
// R22 - Pedestal register holds 8-bit current code, default 180.
// R23 - Auto advance sits at mode bit 11, count-every-trigger at bit 14.
// R24 - Event counter is 24 bits, read as low 16 and high 8; the bank has no register read for it, only the event_count port.
// R25 - Reserved mode positions never change on set or clear writes.
module qdcrb_control_register_bank
	import qdcrb_pkg::*;
#(
	parameter int FIFO_DEPTH = 32,
	parameter int ADDR_BITS  = 16
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rstn,
	// Register access port
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [15:0]              reg_addr,
	input  wire logic [15:0]              reg_wdata,
	output logic      [15:0]              reg_rdata,
	output logic                          reg_ack,
	// Event sources from the acquisition core
	input  wire logic                     trigger,
	input  wire logic                     trigger_accepted,
	input  wire logic                     sample_valid,
	input  wire logic [11:0]              sample_value,
	input  wire logic                     sample_overflow,
	input  wire logic [7:0]               sample_threshold,
	input  wire logic                     event_empty,
	input  wire logic                     test_fifo_pop,
	// Mode and control outputs
	output logic                          memory_test_mode,
	output logic                          converter_offline,
	output logic                          data_reset,
	output logic                          acquisition_test_mode,
	output logic                          sliding_scale_dac_const,
	output logic                          slide_subtract_disable,
	output logic                          auto_advance,
	output logic                          sample_store,
	output logic                          write_header_trailer,
	output logic [9:0]                    clear_window_width,
	output logic [15:0]                   clear_window_cycles,
	output logic [7:0]                    crate_tag,
	output logic [7:0]                    pedestal_code,
	output logic [EVCNT_BITS-1:0]         event_count,
	// Memory test write port into the output buffer
	output logic                          test_mem_wr,
	output logic [ADDR_BITS-1:0]          test_mem_addr,
	output logic [31:0]                   test_mem_data,
	// Test event FIFO read side
	output logic [TEST_WORD_BITS-1:0]     test_fifo_data
);
	// ==========================================================
	// Elaboration checks
	localparam int PTR_BITS = $clog2(FIFO_DEPTH);
	if (FIFO_DEPTH != 32) begin : g_bad_depth
		$error("test event FIFO depth must be 32");
	end
	if (ADDR_BITS < 1 || ADDR_BITS > 16) begin : g_bad_addr
		$error("test address width must be 1 to 16");
	end

	// ==========================================================
	// State record
	typedef struct packed {
		logic [15:0]                  mode;
		logic [9:0]                   fcw;
		logic [7:0]                   crate;
		logic [7:0]                   pedestal;
		logic [ADDR_BITS-1:0]         taddr;
		logic [15:0]                  tupper;
		logic [EVCNT_BITS-1:0]        evcnt;
		logic [FIFO_DEPTH-1:0][TEST_WORD_BITS-1:0] fifo;
		logic [PTR_BITS-1:0]          wptr;
		logic [PTR_BITS-1:0]          rptr;
		logic [15:0]                  rdata;
		logic                         ack;
		logic                         mem_wr;
		logic [31:0]                  mem_data;
		logic                         store;
		logic                         hdr;
		logic [15:0]                  fc_cycles;
		logic [TEST_WORD_BITS-1:0]    tdata;
	} qdcrb_state_t;

	qdcrb_state_t state_reg;
	qdcrb_state_t state_next;

	// Address match helper
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		return a == off;
	endfunction

	// Suppression check for one sample against mode settings
	function automatic logic keep_sample(input logic [15:0] m, input logic [11:0] v,
	                                     input logic ov, input logic [7:0] thr);
		logic [12:0] limit;
		logic        above;
		logic        ok_ov;
		limit = m[MB_THRESHOLD_RES] ? {4'h0, thr, 1'b0} : {1'b0, thr, 4'h0};  // R11
		above = {1'b0, v} >= limit;
		ok_ov = m[MB_OVERFLOW_CHECK_DIS] || !ov;                                // R7
		return ok_ov && (m[MB_THRESHOLD_CHECK_DIS] || above);                 // R8
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		logic [9:0] fcw_w;
		fcw_w = reg_wdata[9:0];

		// Hold every field by default; the pulses and the read data
		// fall back to their idle value unless an access drives them
		state_next        = state_reg;
		state_next.ack    = reg_wr || reg_rd;
		state_next.mem_wr = 1'b0;
		state_next.rdata  = 16'h0000;

		// ------------------------------------------------------
		// Mode set and clear, reserved positions protected.
		// The two sit at different offsets, so only one acts per cycle.
		// Reserved positions are masked out so that software can never
		// disturb them, whatever pattern it writes.
		if (reg_wr && hit(reg_addr, OFF_MODE_SET)) begin
			state_next.mode = state_reg.mode | (reg_wdata & MODE_WRITABLE);     // R2 R25
		end
		if (reg_wr && hit(reg_addr, OFF_MODE_CLEAR)) begin
			state_next.mode = state_reg.mode & ~(reg_wdata & MODE_WRITABLE);    // R3 R25
		end

		// ------------------------------------------------------
		// Fast clear window, clamped to the largest allowed count.
		// Clamping rather than ignoring keeps the window as long as
		// software evidently wanted, within what the timebase allows.
		if (reg_wr && hit(reg_addr, OFF_FAST_CLEAR_WINDOW)) begin
			state_next.fcw = (fcw_w > FCW_MAX) ? FCW_MAX : fcw_w;               // R1
		end

		// Window in system cycles: N ticks of 1/32 us plus 7 us base,
		// rounded up so the window is never shorter than asked.
		// Worked from the stored count, so it trails that count by one cycle.
		state_next.fc_cycles = 16'(FC_BASE_CYCLES
			+ (int'(state_reg.fcw) * SYS_CLK_MHZ + FC_TICK_MHZ - 1) / FC_TICK_MHZ); // R1

		// ------------------------------------------------------
		// Crate number and pedestal code, plain read/write registers
		if (reg_wr && hit(reg_addr, OFF_CRATE_NUMBER)) begin
			state_next.crate = reg_wdata[7:0];                                   // R18
		end
		if (reg_wr && hit(reg_addr, OFF_PEDESTAL_CURRENT)) begin
			state_next.pedestal = reg_wdata[7:0];                                // R22
		end

		// ------------------------------------------------------
		// Memory test: address, upper half, then lower half commits the word.
		// The upper half is only held here; the lower half write is the
		// commit point, and only while test mode is on, so a stray lower
		// half in normal running never reaches the output buffer.
		if (reg_wr && hit(reg_addr, OFF_TEST_WRITE_ADDRESS)) begin
			state_next.taddr = reg_wdata[ADDR_BITS-1:0];
		end
		if (reg_wr && hit(reg_addr, OFF_TEST_WORD_UPPER)) begin
			state_next.tupper = reg_wdata;
		end
		if (reg_wr && hit(reg_addr, OFF_TEST_WORD_LOWER) && state_reg.mode[MB_MEMORY_TEST]) begin
			state_next.mem_wr   = 1'b1;                                          // R15 R4
			state_next.mem_data = {state_reg.tupper, reg_wdata};                 // R15
		end

		// ------------------------------------------------------
		// Test event FIFO: circular, extra writes overwrite oldest entries.
		// Pops only count in acquisition test mode; elsewhere the core
		// may pulse its pop line freely without moving the pointer.
		if (reg_wr && hit(reg_addr, OFF_TEST_EVENT_FIFO)) begin
			state_next.fifo[state_reg.wptr] = reg_wdata[TEST_WORD_BITS-1:0];    // R19
			state_next.wptr = state_reg.wptr + 1'b1;
		end
		if (test_fifo_pop && state_reg.mode[MB_ACQUISITION_TEST]) begin
			state_next.rptr = state_reg.rptr + 1'b1;                             // R9
		end

		// ------------------------------------------------------
		// Event counter: clear strobe and data wipe win over counting.
		// Both clears come after the increment, so a trigger in the
		// same cycle as a clear can never leave a count behind.
		if (trigger && (state_reg.mode[MB_COUNT_EVERY_TRIGGER] || trigger_accepted)) begin
			state_next.evcnt = state_reg.evcnt + 1'b1;                           // R14
		end
		if ((reg_wr && hit(reg_addr, OFF_EVENT_COUNTER_CLEAR)) || state_reg.mode[MB_DATA_WIPE]) begin
			state_next.evcnt = '0;                                               // R21 R6
		end

		// Data wipe holds both FIFO pointers at zero while it is set
		if (state_reg.mode[MB_DATA_WIPE]) begin
			state_next.wptr = '0;                                                // R6
			state_next.rptr = '0;
		end

		// ------------------------------------------------------
		// Sample acceptance and empty-event framing.
		// A sample seen during a data wipe is dropped, since the wipe
		// clears whatever it would have been stored beside.
		state_next.store = sample_valid && keep_sample(state_reg.mode, sample_value,
			sample_overflow, sample_threshold) && !state_reg.mode[MB_DATA_WIPE];
		state_next.hdr   = !event_empty || state_reg.mode[MB_KEEP_EMPTY];         // R13

		// Registered copy of the entry at the read pointer, taken after this
		// cycle's writes, pops and wipes, so the output never shows a stale one
		state_next.tdata = state_next.fifo[state_next.rptr];                      // R9

		// ------------------------------------------------------
		// Read data: only the readable registers answer; write-only
		// and unmapped offsets read as zero
		if (reg_rd) begin
			case (reg_addr)
				OFF_FAST_CLEAR_WINDOW: state_next.rdata = {6'h00, state_reg.fcw};
				OFF_MODE_SET:          state_next.rdata = state_reg.mode;          // R2
				OFF_CRATE_NUMBER:      state_next.rdata = {8'h00, state_reg.crate};
				OFF_PEDESTAL_CURRENT:  state_next.rdata = {8'h00, state_reg.pedestal};
				default:               state_next.rdata = 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg          <= '0;
			state_reg.mode     <= MODE_RESET;
			state_reg.fcw      <= FCW_RESET;
			state_reg.crate    <= CRATE_RESET;
			state_reg.pedestal <= PEDESTAL_RESET;
			state_reg.fc_cycles <= 16'(FC_BASE_CYCLES);
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs, each straight from the state register

	// Register access answer
	assign reg_rdata               = state_reg.rdata;
	assign reg_ack                 = state_reg.ack;

	// Mode levels toward the acquisition core
	assign memory_test_mode        = state_reg.mode[MB_MEMORY_TEST];          // R4
	assign converter_offline       = state_reg.mode[MB_CONVERTER_HALT];       // R5
	assign data_reset              = state_reg.mode[MB_DATA_WIPE];            // R6
	assign acquisition_test_mode   = state_reg.mode[MB_ACQUISITION_TEST];     // R9
	assign sliding_scale_dac_const = !state_reg.mode[MB_SLIDING_SCALE_EN];    // R10
	assign slide_subtract_disable  = state_reg.mode[MB_SLIDE_SUB_DIS];        // R10
	assign auto_advance            = state_reg.mode[MB_AUTO_ADVANCE];         // R12 R23

	// Sample and framing decisions
	assign sample_store            = state_reg.store;
	assign write_header_trailer    = state_reg.hdr;

	// Window, tags and event counter
	assign clear_window_width      = state_reg.fcw;
	assign clear_window_cycles     = state_reg.fc_cycles;
	assign crate_tag               = state_reg.crate;                         // R18
	assign pedestal_code           = state_reg.pedestal;
	assign event_count             = state_reg.evcnt;                         // R24

	// Memory test write port
	assign test_mem_wr             = state_reg.mem_wr;
	assign test_mem_addr           = state_reg.taddr;
	assign test_mem_data           = state_reg.mem_data;

	// Test event FIFO read side
	assign test_fifo_data          = state_reg.tdata;                         // R9
endmodule

// ==== dv/qdcrb_checker_assertions.sv ====
// Concurrent checks on the ports of the control register bank
module qdcrb_checker
	import qdcrb_pkg::*;
(
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  rstn,
	// Register access port
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [15:0]           reg_addr,
	input wire logic [15:0]           reg_wdata,
	input wire logic                  reg_ack,
	// Event inputs and watched outputs
	input wire logic                  trigger,
	input wire logic                  trigger_accepted,
	input wire logic                  memory_test_mode,
	input wire logic                  data_reset,
	input wire logic [9:0]            clear_window_width,
	input wire logic [7:0]            pedestal_code,
	input wire logic [EVCNT_BITS-1:0] event_count,
	input wire logic                  test_mem_wr,
	input wire logic [31:0]           test_mem_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// A write taken at one offset
	sequence s_wr(logic [15:0] a);
		reg_wr && reg_addr == a;
	endsequence
	// Upper half, two idle cycles, then lower half in test mode
	sequence s_upper_then_lower;
		s_wr(OFF_TEST_WORD_UPPER) ##3 s_wr(OFF_TEST_WORD_LOWER) ##0 memory_test_mode;
	endsequence
	// Access answers and mode register edits
	a_access_acked: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("access not acknowledged");
	a_set_test_bit: assert property (s_wr(OFF_MODE_SET) ##0 reg_wdata[0] |=> memory_test_mode) else $error("set lost");
	a_clear_wipe_bit: assert property (s_wr(OFF_MODE_CLEAR) ##0 reg_wdata[2] |=> !data_reset) else $error("clear lost");
	// Event counter
	a_wipe_zero_count: assert property (data_reset |=> event_count == '0) else $error("wipe kept count");
	a_strobe_zero_count: assert property (s_wr(OFF_EVENT_COUNTER_CLEAR) |=> event_count == '0) else $error("not cleared");
	a_accepted_counts: assert property (trigger && trigger_accepted && !data_reset && !reg_wr
		|=> event_count == $past(event_count) + 1'b1) else $error("accepted trigger not counted");
	// Window, pedestal and memory test commits
	a_window_limit: assert property (clear_window_width <= FCW_MAX) else $error("window above limit");
	a_pedestal_load: assert property (s_wr(OFF_PEDESTAL_CURRENT) |=> pedestal_code == 8'($past(reg_wdata)))
		else $error("pedestal not loaded");
	a_lower_commits: assert property (s_wr(OFF_TEST_WORD_LOWER) ##0 memory_test_mode
		|=> test_mem_wr && test_mem_data[15:0] == $past(reg_wdata)) else $error("test word not committed");
	a_word_joins_halves: assert property (s_upper_then_lower
		|=> test_mem_data[31:16] == $past(reg_wdata, 4)) else $error("upper half lost");
	a_commit_needs_write: assert property (!reg_wr |=> !test_mem_wr) else $error("spurious test write");
endmodule

bind qdcrb_control_register_bank qdcrb_checker u_chk (.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
	.reg_ack, .trigger, .trigger_accepted, .memory_test_mode, .data_reset, .clear_window_width, .pedestal_code,
	.event_count, .test_mem_wr, .test_mem_data);

// ==== dv/qdcrb_host_model.sv ====
// Host that reaches the register bank with single-word accesses
module qdcrb_host_model
	import qdcrb_pkg::*;
(
	// Clock
	input wire logic        sys_clk,
	// Register access port
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [15:0]     reg_addr,
	output logic [15:0]     reg_wdata,
	input wire logic [15:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle lines at time zero
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	end
	// One-cycle strobe; read data stands only in the cycle after it, so it is
	// taken before the lines go to junk, then one more cycle lets outputs settle
	task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
		@(negedge sys_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(negedge sys_clk);
		q = reg_rdata;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
		@(negedge sys_clk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] q;
		access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] q);
		access(1'b0, a, 16'h0000, q);
	endtask
	// Memory test order: test mode, address, upper half, lower half
	task automatic test_word(input logic [15:0] a, input logic [15:0] h, input logic [15:0] l);
		wr(OFF_MODE_SET, 16'h0001);
		wr(OFF_TEST_WRITE_ADDRESS, a);
		wr(OFF_TEST_WORD_UPPER, h);
		wr(OFF_TEST_WORD_LOWER, l);
	endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking testbench for the control register bank
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import qdcrb_pkg::*;
	logic        sys_clk, rstn, reg_wr, reg_rd, reg_ack, trigger, trigger_accepted, sample_valid, sample_overflow;
	logic        event_empty, test_fifo_pop, memory_test_mode, converter_offline, data_reset, acquisition_test_mode;
	logic        sliding_scale_dac_const, slide_subtract_disable, auto_advance, sample_store, write_header_trailer;
	logic        test_mem_wr;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, clear_window_cycles, test_mem_addr, rnd;
	logic [11:0] sample_value;
	logic [7:0]  sample_threshold, crate_tag, pedestal_code;
	logic [9:0]  clear_window_width;
	logic [23:0] event_count;
	logic [31:0] test_mem_data;
	logic [12:0] test_fifo_data;
	logic [6:0]  mode_pins;
	int          errors, comparisons, mode, count, mem_writes;
	logic [47:0] mem_seen;
	// Design, host and clock
	qdcrb_control_register_bank u_dut (.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
		.trigger, .trigger_accepted, .sample_valid, .sample_value, .sample_overflow, .sample_threshold, .event_empty,
		.test_fifo_pop, .memory_test_mode, .converter_offline, .data_reset, .acquisition_test_mode,
		.sliding_scale_dac_const, .slide_subtract_disable, .auto_advance, .sample_store, .write_header_trailer,
		.clear_window_width, .clear_window_cycles, .crate_tag, .pedestal_code, .event_count, .test_mem_wr,
		.test_mem_addr, .test_mem_data, .test_fifo_data);
	qdcrb_host_model u_host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
	always #4 sys_clk = ~sys_clk;
	assign mode_pins = {memory_test_mode, converter_offline, data_reset, acquisition_test_mode,
		sliding_scale_dac_const, slide_subtract_disable, auto_advance};
	// Catch each one-cycle test write while it stands
	always @(negedge sys_clk) begin
		if (test_mem_wr === 1'b1) begin
			mem_writes++;
			mem_seen = {test_mem_addr, test_mem_data};
		end
	end
	// Random source and comparison helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
		logic [15:0] q;
		u_host.rd(a, q);
		chk(what, exp, q);
	endtask
	task automatic finish_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Watchdog cuts a hang short
	initial begin
		#100000;
		errors++;
		finish_test();
	end
	// Main sequence
	initial begin
		{sys_clk, rstn, trigger, trigger_accepted, sample_valid, sample_overflow, event_empty, test_fifo_pop} = '0;
		{sample_value, sample_threshold} = '0;
		rnd = 16'h9cf5;
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		rd_chk(OFF_MODE_SET, MODE_RESET, "mode");
		rd_chk(OFF_PEDESTAL_CURRENT, 16'h00b4, "pedestal");
		rd_chk(OFF_MODE_CLEAR, 16'h0000, "write-only read");
		rd_chk(16'h1042, 16'h0000, "unmapped read");
		u_host.wr(OFF_FAST_CLEAR_WINDOW, 16'h03ff);
		rd_chk(OFF_FAST_CLEAR_WINDOW, 16'h03f0, "window");
		chk("window cycles", 875 + (12'h3f0 * 125 + 31) / 32, clear_window_cycles);
		chk("window width", 10'h3f0, clear_window_width);
		u_host.wr(OFF_CRATE_NUMBER, 16'h0027);
		u_host.wr(OFF_PEDESTAL_CURRENT, 16'h003c);
		rd_chk(OFF_CRATE_NUMBER, 16'h0027, "crate");
		chk("tags", 16'h273c, {crate_tag, pedestal_code});
		$display("test registers done");
		mode = MODE_RESET;
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			u_host.wr(OFF_MODE_CLEAR, rnd);
			mode = mode & ~(rnd & MODE_WRITABLE);
			rnd = lfsr(rnd);
			u_host.wr(OFF_MODE_SET, rnd);
			mode = mode | (rnd & MODE_WRITABLE);
			rd_chk(OFF_MODE_SET, 16'(mode), "mode");
			chk("mode pins", {mode[0], mode[1], mode[2], mode[6], !mode[7], mode[13], mode[11]}, mode_pins);
			rnd = lfsr(rnd);
			{sample_value, sample_overflow, event_empty, trigger_accepted} = {rnd[11:0], rnd[12], rnd[13], rnd[14]};
			sample_threshold = rnd[15:8];
			{trigger, sample_valid} = 2'b11;
			@(negedge sys_clk);
			{trigger, sample_valid} = 2'b00;
			count = mode[2] ? 0 : (count + int'(mode[14] || trigger_accepted)) & 24'hffffff;
			chk("store", (!sample_overflow || mode[3]) && !mode[2] && (mode[4] || sample_value >= sample_threshold
				* (mode[8] ? 2 : 16)), sample_store);
			chk("header", !event_empty || mode[12], write_header_trailer);
			if (i % 4 == 3) begin
				u_host.wr(OFF_EVENT_COUNTER_CLEAR, rnd);
				count = 0;
			end
			chk("event count", count, event_count);
		end
		$display("test mode loop done");
		u_host.wr(OFF_MODE_CLEAR, 16'hffff);
		u_host.test_word(16'h0005, 16'hbeef, 16'h1234);
		chk("test write", {16'h0005, 32'hbeef1234}, mem_seen);
		chk("test writes", 1, mem_writes);
		u_host.wr(OFF_MODE_CLEAR, 16'h0001);
		u_host.wr(OFF_TEST_WORD_LOWER, 16'h5678);
		chk("test write off", 1, mem_writes);
		chk("test strobe", 1'b0, test_mem_wr);
		u_host.wr(OFF_MODE_SET, 16'h0004);
		u_host.wr(OFF_MODE_CLEAR, 16'h0004);
		for (int k = 0; k < 32; k++) u_host.wr(OFF_TEST_EVENT_FIFO, 16'(k * 16'h00a5 + 16'h0111));
		chk("fifo head", 13'h0111, test_fifo_data);
		u_host.wr(OFF_MODE_SET, 16'h0040);
		test_fifo_pop = 1'b1;
		@(negedge sys_clk);
		test_fifo_pop = 1'b0;
		chk("fifo next", 13'h01b6, test_fifo_data);
		$display("test memory and fifo done");
		finish_test();
	end
endmodule
